/* core/cal_core.sv */
// ALU datapath with APB register access and low I/O single-bit access
`timescale 1ns/1ps
`default_nettype none
module cal_core #(
   parameter int IO_REGS = 32
) (
   input wire logic MCLK,
   input wire logic RESETN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Masked-write and read port to the low I/O registers
   output logic [5:0] IO_ADDR,
   output logic [7:0] IO_WDATA,
   output logic [7:0] IO_WMASK,
   output logic IO_WE,
   input wire logic [7:0] IO_RDATA,
   output logic SKIP
);
   logic [4:0] op_code;
   logic start;
   cal_pkg::cal_operands_t opnd;
   cal_pkg::cal_io_ref_t ioref;
   logic [7:0] result;
   logic [15:0] word_result;
   logic [5:0] flags;
   logic busy;
   logic skip_q;
   cal_pkg::cal_state_t state;
   logic [15:0] word_sum;
   logic word_c_lo;
   logic [8:0] word_lo;
   logic [7:0] word_hi;
   logic word_v;
   logic word_c;

   logic [7:0] next_res;
   logic [5:0] next_flags;
   logic write_res;
   logic [8:0] wide;
   logic [7:0] bop;
   logic cin;
   logic [7:0] sub_a;

   logic setup_ok;
   logic wr_acc;
   logic [7:0] io_lo_addr;
   logic io_in_range;
   cal_pkg::cal_op_t op;

   assign op = cal_pkg::cal_op_t'(op_code);
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign setup_ok = PSEL && PENABLE;
   assign PREADY = 1'b1;
   assign PSLVERR = setup_ok && !(PADDR == cal_pkg::REG_OPCTL || PADDR == cal_pkg::REG_OPERAND
      || PADDR == cal_pkg::REG_RESULT || PADDR == cal_pkg::REG_FLAGS
      || PADDR == cal_pkg::REG_WORD || PADDR == cal_pkg::REG_STATUS);

   // Control and operand registers
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         op_code <= 5'h00;
         ioref <= '0;
         opnd <= '0;
         start <= 1'b0;
      end else begin
         start <= 1'b0;
         if (wr_acc && PADDR == cal_pkg::REG_OPCTL && !busy) begin
            op_code <= PWDATA[4:0];
            ioref.bit_sel <= PWDATA[10:8];
            ioref.addr <= PWDATA[21:16];
            start <= PWDATA[31];
         end
         if (wr_acc && PADDR == cal_pkg::REG_OPERAND) begin
            opnd.dst <= PWDATA[7:0];
            opnd.src <= PWDATA[15:8];
            opnd.imm <= PWDATA[23:16];
         end
         if (wr_acc && PADDR == cal_pkg::REG_WORD) begin
            opnd.pair <= PWDATA[15:0];
         end
      end
   end

   always_comb begin
      PRDATA = 32'h0000_0000;
      if (PSEL && !PWRITE) begin
         unique case (PADDR)
            cal_pkg::REG_OPCTL: PRDATA = {10'h000, ioref.addr, 5'h00, ioref.bit_sel, 3'h0, op_code};
            cal_pkg::REG_OPERAND: PRDATA = {8'h00, opnd.imm, opnd.src, opnd.dst};
            cal_pkg::REG_RESULT: PRDATA = {24'h000000, result};
            cal_pkg::REG_FLAGS: PRDATA = {26'h0000000, flags};
            cal_pkg::REG_WORD: PRDATA = {word_result, opnd.pair};
            cal_pkg::REG_STATUS: PRDATA = {30'h00000000, skip_q, busy};
            default: PRDATA = 32'h0000_0000;
         endcase
      end
   end

   // Byte operations: operand b, carry in and result with flags
   always_comb begin
      bop = opnd.src;
      cin = 1'b0;
      sub_a = opnd.dst;
      wide = 9'h000;
      next_res = result;
      next_flags = flags;
      write_res = 1'b0;
      unique case (op)
         cal_pkg::OP_ADD, cal_pkg::OP_ADD_CARRY: begin
            cin = (op == cal_pkg::OP_ADD_CARRY) ? flags[cal_pkg::FLG_C] : 1'b0;
            wide = {1'b0, opnd.dst} + {1'b0, opnd.src} + {8'h00, cin};
            next_res = wide[7:0];
            next_flags[cal_pkg::FLG_C] = wide[8];
            next_flags[cal_pkg::FLG_H] = (opnd.dst[3] & opnd.src[3]) | (opnd.src[3] & ~wide[3])
               | (~wide[3] & opnd.dst[3]);
            next_flags[cal_pkg::FLG_V] = (opnd.dst[7] & opnd.src[7] & ~wide[7])
               | (~opnd.dst[7] & ~opnd.src[7] & wide[7]);
            write_res = 1'b1;
         end
         cal_pkg::OP_SUB, cal_pkg::OP_DIFFERENCE_CONSTANT, cal_pkg::OP_DIFFERENCE_WITH_BORROW,
         cal_pkg::OP_DIFFERENCE_CONST_BORROW, cal_pkg::OP_ARITH_INVERSE: begin
            bop = (op == cal_pkg::OP_SUB || op == cal_pkg::OP_DIFFERENCE_WITH_BORROW)
               ? opnd.src : opnd.imm;
            cin = (op == cal_pkg::OP_DIFFERENCE_WITH_BORROW
               || op == cal_pkg::OP_DIFFERENCE_CONST_BORROW) ? flags[cal_pkg::FLG_C] : 1'b0;
            if (op == cal_pkg::OP_ARITH_INVERSE) begin
               bop = opnd.dst;
            end
            wide = (op == cal_pkg::OP_ARITH_INVERSE)
               ? {1'b0, cal_pkg::ALL_ZERO} - {1'b0, bop}
               : {1'b0, opnd.dst} - {1'b0, bop} - {8'h00, cin};
            next_res = wide[7:0];
            next_flags[cal_pkg::FLG_C] = wide[8];
            sub_a = (op == cal_pkg::OP_ARITH_INVERSE) ? cal_pkg::ALL_ZERO : opnd.dst;
            next_flags[cal_pkg::FLG_H] = (~sub_a[3] & bop[3]) | (bop[3] & wide[3])
               | (wide[3] & ~sub_a[3]);
            next_flags[cal_pkg::FLG_V] = (sub_a[7] & ~bop[7] & ~wide[7])
               | (~sub_a[7] & bop[7] & wide[7]);
            write_res = 1'b1;
         end
         cal_pkg::OP_AND, cal_pkg::OP_CONJUNCTION_CONSTANT, cal_pkg::OP_OR,
         cal_pkg::OP_DISJUNCTION_CONSTANT, cal_pkg::OP_EXCLUSIVE_DISJUNCTION,
         cal_pkg::OP_MASK_BITS_SET, cal_pkg::OP_MASK_BITS_CLEAR, cal_pkg::OP_ZERO_REGISTER: begin
            unique case (op)
               cal_pkg::OP_AND: next_res = opnd.dst & opnd.src;
               cal_pkg::OP_CONJUNCTION_CONSTANT: next_res = opnd.dst & opnd.imm;
               cal_pkg::OP_OR: next_res = opnd.dst | opnd.src;
               cal_pkg::OP_DISJUNCTION_CONSTANT: next_res = opnd.dst | opnd.imm;
               cal_pkg::OP_EXCLUSIVE_DISJUNCTION: next_res = opnd.dst ^ opnd.src;
               cal_pkg::OP_MASK_BITS_SET: next_res = opnd.dst | opnd.imm;
               cal_pkg::OP_MASK_BITS_CLEAR: next_res = opnd.dst & (cal_pkg::ALL_ONES - opnd.imm);
               default: next_res = opnd.dst ^ opnd.dst;
            endcase
            next_flags[cal_pkg::FLG_V] = 1'b0;
            write_res = 1'b1;
         end
         cal_pkg::OP_BITWISE_INVERT: begin
            next_res = cal_pkg::ALL_ONES - opnd.dst;
            next_flags[cal_pkg::FLG_C] = 1'b1;
            next_flags[cal_pkg::FLG_V] = 1'b0;
            write_res = 1'b1;
         end
         cal_pkg::OP_PLUS_ONE, cal_pkg::OP_MINUS_ONE: begin
            next_res = (op == cal_pkg::OP_PLUS_ONE) ? opnd.dst + 8'h01 : opnd.dst - 8'h01;
            next_flags[cal_pkg::FLG_V] = (op == cal_pkg::OP_PLUS_ONE)
               ? (opnd.dst == 8'h7f) : (opnd.dst == 8'h80);
            write_res = 1'b1;
         end
         cal_pkg::OP_ALL_ONES_REGISTER: begin
            next_res = cal_pkg::ALL_ONES;
         end
         default: begin
            next_res = result;
         end
      endcase
      if (write_res) begin
         next_flags[cal_pkg::FLG_Z] = (next_res == 8'h00);
         next_flags[cal_pkg::FLG_N] = next_res[7];
         next_flags[cal_pkg::FLG_S] = next_res[7] ^ next_flags[cal_pkg::FLG_V];
      end
   end

   // Word ops: low byte at start, high byte with the low carry on the next clock
   always_comb begin
      word_lo = (op == cal_pkg::OP_WORD_IMMEDIATE_SUM)
         ? {1'b0, opnd.pair[7:0]} + {1'b0, opnd.imm}
         : {1'b0, opnd.pair[7:0]} - {1'b0, opnd.imm};
      word_hi = (op == cal_pkg::OP_WORD_IMMEDIATE_SUM)
         ? opnd.pair[15:8] + {7'h00, word_c_lo} : opnd.pair[15:8] - {7'h00, word_c_lo};
      word_v = (op == cal_pkg::OP_WORD_IMMEDIATE_SUM)
         ? (~opnd.pair[15] & word_hi[7]) : (opnd.pair[15] & ~word_hi[7]);
      word_c = (op == cal_pkg::OP_WORD_IMMEDIATE_SUM)
         ? (~word_hi[7] & opnd.pair[15]) : (word_hi[7] & ~opnd.pair[15]);
   end

   // Byte ops finish in the start cycle; word ops take a second clock for the high byte
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         state <= cal_pkg::ST_IDLE;
         result <= cal_pkg::RESULT_RST;
         flags <= cal_pkg::FLAGS_RST;
         word_result <= cal_pkg::WORD_RST;
         word_sum <= cal_pkg::WORD_RST;
         word_c_lo <= 1'b0;
      end else begin
         unique case (state)
            cal_pkg::ST_IDLE: begin
               if (start && (op == cal_pkg::OP_WORD_IMMEDIATE_SUM
                  || op == cal_pkg::OP_WORD_IMMEDIATE_DIFFERENCE)) begin
                  // Low byte first; its carry is kept for the high byte
                  word_sum[7:0] <= word_lo[7:0];
                  word_c_lo <= word_lo[8];
                  state <= cal_pkg::ST_WORD_HIGH;
               end else if (start) begin
                  result <= next_res;
                  flags <= next_flags;
               end
            end
            cal_pkg::ST_WORD_HIGH: begin
               word_result <= {word_hi, word_sum[7:0]};
               flags[cal_pkg::FLG_V] <= word_v;
               flags[cal_pkg::FLG_C] <= word_c;
               flags[cal_pkg::FLG_N] <= word_hi[7];
               flags[cal_pkg::FLG_S] <= word_hi[7] ^ word_v;
               flags[cal_pkg::FLG_Z] <= ({word_hi, word_sum[7:0]} == 16'h0000);
               state <= cal_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // I/O bit access: a masked write, so only the addressed bit changes
   assign io_lo_addr = {2'b00, ioref.addr};
   assign io_in_range = (ioref.addr <= cal_pkg::IO_BIT_HI) && (io_lo_addr < IO_REGS[7:0]);
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         IO_ADDR <= 6'h00;
         IO_WDATA <= 8'h00;
         IO_WMASK <= 8'h00;
         IO_WE <= 1'b0;
         skip_q <= 1'b0;
         busy <= 1'b0;
      end else begin
         IO_WE <= 1'b0;
         busy <= start && (op == cal_pkg::OP_WORD_IMMEDIATE_SUM
            || op == cal_pkg::OP_WORD_IMMEDIATE_DIFFERENCE);
         // Loaded with the op itself, so a skip test reads the addressed register at once
         if (wr_acc && PADDR == cal_pkg::REG_OPCTL && !busy) begin
            IO_ADDR <= PWDATA[21:16];
         end
         if (start && io_in_range && (op == cal_pkg::OP_IO_BIT_SET || op == cal_pkg::OP_IO_BIT_CLEAR)) begin
            // Mask keeps write-one-to-clear neighbours untouched
            IO_WMASK <= 8'h01 << ioref.bit_sel;
            IO_WDATA <= (op == cal_pkg::OP_IO_BIT_SET) ? (8'h01 << ioref.bit_sel) : 8'h00;
            IO_WE <= 1'b1;
         end
         if (start && io_in_range && (op == cal_pkg::OP_SKIP_IF_IO_BIT_ONE
            || op == cal_pkg::OP_SKIP_IF_IO_BIT_ZERO)) begin
            skip_q <= (IO_RDATA[ioref.bit_sel] == (op == cal_pkg::OP_SKIP_IF_IO_BIT_ONE));
         end else if (start) begin
            skip_q <= 1'b0;
         end
      end
   end
   assign SKIP = skip_q;
endmodule
`default_nettype wire

/* core/cal_pkg.sv */
// Package: operation codes, flag layout, I/O bit-access constants for the ALU datapath
package cal_pkg;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam int IO_ADDR_W = 6;
   // Bit-accessible I/O range
   localparam logic [5:0] IO_BIT_LO = 6'h00;
   localparam logic [5:0] IO_BIT_HI = 6'h1f;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ALL_ZERO = 8'h00;
   // Status flag positions in the flag word
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   // Clock counts
   localparam int CYC_BYTE_OP = 1;
   localparam int CYC_WORD_OP = 2;

   // APB register map (byte addresses)
   localparam logic [7:0] REG_OPCTL = 8'h00;
   localparam logic [7:0] REG_OPERAND = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0c;
   localparam logic [7:0] REG_WORD = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;

   typedef enum logic [4:0] {
      OP_ADD = 5'h00,
      OP_ADD_CARRY = 5'h01,
      OP_WORD_IMMEDIATE_SUM = 5'h02,
      OP_SUB = 5'h03,
      OP_DIFFERENCE_CONSTANT = 5'h04,
      OP_DIFFERENCE_WITH_BORROW = 5'h05,
      OP_DIFFERENCE_CONST_BORROW = 5'h06,
      OP_WORD_IMMEDIATE_DIFFERENCE = 5'h07,
      OP_AND = 5'h08,
      OP_CONJUNCTION_CONSTANT = 5'h09,
      OP_OR = 5'h0a,
      OP_DISJUNCTION_CONSTANT = 5'h0b,
      OP_EXCLUSIVE_DISJUNCTION = 5'h0c,
      OP_MASK_BITS_SET = 5'h0d,
      OP_MASK_BITS_CLEAR = 5'h0e,
      OP_BITWISE_INVERT = 5'h0f,
      OP_ARITH_INVERSE = 5'h10,
      OP_PLUS_ONE = 5'h11,
      OP_MINUS_ONE = 5'h12,
      OP_ZERO_REGISTER = 5'h13,
      OP_ALL_ONES_REGISTER = 5'h14,
      OP_IO_BIT_SET = 5'h15,
      OP_IO_BIT_CLEAR = 5'h16,
      OP_SKIP_IF_IO_BIT_ONE = 5'h17,
      OP_SKIP_IF_IO_BIT_ZERO = 5'h18
   } cal_op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WORD_HIGH = 1'b1
   } cal_state_t;

   // Operands presented by the register file
   typedef struct packed {
      logic [7:0] dst;
      logic [7:0] src;
      logic [7:0] imm;
      logic [15:0] pair;
   } cal_operands_t;

   // Bit access toward the I/O space
   typedef struct packed {
      logic [5:0] addr;
      logic [2:0] bit_sel;
   } cal_io_ref_t;
endpackage

/* verification/cal_core_chk.sv */
// Port checker for the ALU datapath: APB answers and low I/O bit access
`timescale 1ns/1ps
`default_nettype none
module cal_core_chk (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [5:0] IO_ADDR,
   input wire logic [7:0] IO_WDATA,
   input wire logic [7:0] IO_WMASK,
   input wire logic IO_WE,
   input wire logic [7:0] IO_RDATA,
   input wire logic SKIP
);
   logic start_wr;
   logic io_op;
   logic skip_op;
   logic in_rng;
   logic io_go;
   logic unmapped;
   logic [2:0] hist;
   logic [5:0] cap_addr;
   logic [2:0] cap_bit;
   logic cap_set;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   assign start_wr = PSEL && PENABLE && PWRITE && PADDR == cal_pkg::REG_OPCTL && PWDATA[31];
   assign io_op = PWDATA[4:0] inside {cal_pkg::OP_IO_BIT_SET, cal_pkg::OP_IO_BIT_CLEAR};
   assign skip_op = PWDATA[4:0] inside {cal_pkg::OP_SKIP_IF_IO_BIT_ONE, cal_pkg::OP_SKIP_IF_IO_BIT_ZERO};
   assign in_rng = PWDATA[21:16] <= cal_pkg::IO_BIT_HI;
   assign io_go = start_wr && io_op && in_rng;
   assign unmapped = !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14});
   // A start too soon after another may be refused while busy, so those are not judged
   always_ff @(posedge MCLK) begin
      if (!RESETN) hist <= 3'h0;
      else hist <= {hist[1:0], start_wr};
   end
   always_ff @(posedge MCLK) begin
      if (start_wr) begin
         cap_addr <= PWDATA[21:16];
         cap_bit <= PWDATA[10:8];
         cap_set <= PWDATA[4:0] == cal_pkg::OP_IO_BIT_SET;
      end
   end
   chk_ready_high: assert property (PREADY) else $error("ready low");
   chk_slverr_map: assert property (PSLVERR == (PSEL && PENABLE && unmapped))
      else $error("error response wrong");
   chk_prdata_idle: assert property (!(PSEL && !PWRITE) |-> PRDATA == 32'h0)
      else $error("read data not idle");
   chk_io_access: assert property (io_go && hist == 3'h0 |-> ##[1:2] (IO_WE && IO_ADDR == cap_addr
      && IO_WMASK == (8'h01 << cap_bit) && IO_WDATA[cap_bit] == cap_set))
      else $error("bit access wrong");
   chk_io_range: assert property (start_wr && io_op && !in_rng && hist == 3'h0 |=> !IO_WE [*2])
      else $error("write outside bit range");
   chk_we_cause: assert property ($rose(IO_WE) |-> $past(io_go) || $past(io_go, 2))
      else $error("write without request");
   chk_we_pulse: assert property (IO_WE |=> !IO_WE) else $error("write strobe too long");
   chk_mask_single: assert property (IO_WE |-> $onehot(IO_WMASK))
      else $error("more than one bit written");
   chk_skip_clear: assert property (start_wr && !skip_op && hist == 3'h0 |-> ##[1:2] !SKIP)
      else $error("skip not cleared");
   chk_skip_hold: assert property ($changed(SKIP) |-> $past(start_wr) || $past(start_wr, 2))
      else $error("skip changed alone");
   cover property (io_go);
   cover property ($rose(SKIP));
   cover property (PSLVERR);
endmodule
`default_nettype wire

/* verification/cal_io_model.sv */
// Low I/O register space model with one register of write-one-to-clear flags
`timescale 1ns/1ps
`default_nettype none
module cal_io_model #(
   parameter logic [4:0] FLAG_ADDR = 5'h0e,
   parameter logic [7:0] FLAG_BITS = 8'hf0,
   parameter logic [7:0] FLAG_INIT = 8'hf5
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_wmask,
   input wire logic io_we,
   output logic [7:0] io_rdata,
   input wire logic [4:0] probe_addr,
   output logic [7:0] probe_data,
   output logic [7:0] we_count
);
   logic [7:0] mem [0:31];
   logic [7:0] tog;
   // Outside the space the lines float, so they show a changing pattern
   assign io_rdata = io_addr < 6'h20 ? mem[io_addr[4:0]] : tog;
   assign probe_data = mem[probe_addr];
   always_ff @(posedge mclk) begin
      tog <= ~tog;
      if (!resetn) begin
         tog <= 8'h5a;
         we_count <= 8'h00;
         for (int i = 0; i < 32; i++) mem[i] <= 8'h00;
         mem[FLAG_ADDR] <= FLAG_INIT;
      end else if (io_we) begin
         we_count <= we_count + 8'h01;
         for (int i = 0; i < 8; i++) begin
            if (io_wmask[i] && io_addr < 6'h20) begin
               if (io_addr[4:0] == FLAG_ADDR && FLAG_BITS[i]) begin
                  if (io_wdata[i]) mem[io_addr[4:0]][i] <= 1'b0;
               end else begin
                  mem[io_addr[4:0]][i] <= io_wdata[i];
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* verification/test_cal_core.sv */
// Self-checking bench of the ALU datapath over APB with an I/O space model
`timescale 1ns/1ps
`default_nettype none
module test_cal_core;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] io_addr;
   logic [7:0] io_wdata;
   logic [7:0] io_wmask;
   logic io_we;
   logic [7:0] io_rdata;
   logic skip;
   logic [4:0] probe_addr = 5'h00;
   logic [7:0] probe_data;
   logic [7:0] we_count;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic er;
   always #2.5 mclk = ~mclk;
   cal_core cal_core_i (.MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_WMASK(io_wmask),
      .IO_WE(io_we), .IO_RDATA(io_rdata), .SKIP(skip));
   cal_io_model cal_io_model_i (.mclk(mclk), .resetn(resetn), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wmask(io_wmask), .io_we(io_we), .io_rdata(io_rdata),
      .probe_addr(probe_addr), .probe_data(probe_data), .we_count(we_count));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Entered just after a rising edge; leaves one idle cycle so strobes never toggle twice
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic start(input cal_pkg::cal_op_t op, input logic [5:0] a, input logic [2:0] b);
      apb(1'b1, cal_pkg::REG_OPCTL, {1'b1, 9'h0, a, 5'h0, b, 3'h0, op});
      repeat (4) @(posedge mclk);
   endtask
   task automatic bop(input cal_pkg::cal_op_t op, input logic [7:0] d, s, k, res, input logic [5:0] f);
      apb(1'b1, cal_pkg::REG_OPERAND, {8'h00, k, s, d});
      start(op, 6'h00, 3'h0);
      apb(1'b0, cal_pkg::REG_RESULT, 32'h0);
      check("result", rd, {24'h0, res});
      apb(1'b0, cal_pkg::REG_FLAGS, 32'h0);
      check("flags", rd, {26'h0, f});
   endtask
   task automatic wop(input cal_pkg::cal_op_t op, input logic [15:0] p, r, input logic [7:0] k,
         input logic [5:0] f);
      apb(1'b1, cal_pkg::REG_WORD, {16'h0, p});
      apb(1'b1, cal_pkg::REG_OPERAND, {8'h00, k, 16'h0});
      start(op, 6'h00, 3'h0);
      apb(1'b0, cal_pkg::REG_WORD, 32'h0);
      check("word", rd[31:16], r);
      apb(1'b0, cal_pkg::REG_FLAGS, 32'h0);
      check("word_flags", rd, {26'h0, f});
   endtask
   task automatic iop(input cal_pkg::cal_op_t op, input logic [5:0] a, input logic [2:0] b,
         input logic [7:0] exp);
      start(op, a, b);
      probe_addr <= a[4:0];
      @(posedge mclk);
      check("io_reg", probe_data, exp);
   endtask
   task automatic skp(input cal_pkg::cal_op_t op, input logic [5:0] a, input logic [2:0] b,
         input logic exp);
      start(op, a, b);
      check("skip_port", skip, exp);
      apb(1'b0, cal_pkg::REG_STATUS, 32'h0);
      check("skip_status", rd[1], exp);
   endtask
   task automatic test_reset();
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         if (i != 0) check("reset_value", rd, 32'h0);
         check("mapped_error", er, 1'b0);
      end
      $display("reset test done");
   endtask
   task automatic test_byte();
      bop(cal_pkg::OP_ADD, 8'h8f, 8'h71, 8'h00, 8'h00, 6'h23);
      bop(cal_pkg::OP_ADD_CARRY, 8'h7f, 8'h00, 8'h00, 8'h80, 6'h2c);
      bop(cal_pkg::OP_SUB, 8'h10, 8'h20, 8'h00, 8'hf0, 6'h15);
      bop(cal_pkg::OP_DIFFERENCE_CONST_BORROW, 8'h00, 8'h00, 8'h00, 8'hff, 6'h35);
      bop(cal_pkg::OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h00, 6'h23);
      bop(cal_pkg::OP_DIFFERENCE_WITH_BORROW, 8'h80, 8'h00, 8'h00, 8'h7f, 6'h38);
      bop(cal_pkg::OP_OR, 8'h40, 8'h01, 8'h00, 8'h41, 6'h20);
      bop(cal_pkg::OP_DIFFERENCE_CONSTANT, 8'h05, 8'h00, 8'h05, 8'h00, 6'h02);
      bop(cal_pkg::OP_DISJUNCTION_CONSTANT, 8'h00, 8'h00, 8'h80, 8'h80, 6'h14);
      bop(cal_pkg::OP_EXCLUSIVE_DISJUNCTION, 8'haa, 8'haa, 8'h00, 8'h00, 6'h02);
      bop(cal_pkg::OP_CONJUNCTION_CONSTANT, 8'hff, 8'h00, 8'h0f, 8'h0f, 6'h00);
      bop(cal_pkg::OP_MASK_BITS_SET, 8'h01, 8'h00, 8'h80, 8'h81, 6'h14);
      bop(cal_pkg::OP_MASK_BITS_CLEAR, 8'hff, 8'h00, 8'h0f, 8'hf0, 6'h14);
      bop(cal_pkg::OP_BITWISE_INVERT, 8'h00, 8'h00, 8'h00, 8'hff, 6'h15);
      bop(cal_pkg::OP_PLUS_ONE, 8'h7f, 8'h00, 8'h00, 8'h80, 6'h0d);
      bop(cal_pkg::OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h7f, 6'h19);
      bop(cal_pkg::OP_ARITH_INVERSE, 8'h01, 8'h00, 8'h00, 8'hff, 6'h35);
      bop(cal_pkg::OP_ZERO_REGISTER, 8'h5a, 8'h00, 8'h00, 8'h00, 6'h23);
      bop(cal_pkg::OP_ARITH_INVERSE, 8'h00, 8'h00, 8'h00, 8'h00, 6'h02);
      bop(cal_pkg::OP_ALL_ONES_REGISTER, 8'h00, 8'h00, 8'h00, 8'hff, 6'h02);
      $display("byte test done");
   endtask
   task automatic test_word();
      wop(cal_pkg::OP_WORD_IMMEDIATE_SUM, 16'hffff, 16'h0000, 8'h01, 6'h03);
      wop(cal_pkg::OP_WORD_IMMEDIATE_SUM, 16'h7fff, 16'h8000, 8'h01, 6'h0c);
      wop(cal_pkg::OP_WORD_IMMEDIATE_DIFFERENCE, 16'h0000, 16'hffff, 8'h01, 6'h15);
      wop(cal_pkg::OP_WORD_IMMEDIATE_DIFFERENCE, 16'h8000, 16'h7fff, 8'h01, 6'h18);
      $display("word test done");
   endtask
   task automatic test_io();
      iop(cal_pkg::OP_IO_BIT_SET, 6'h0e, 3'h5, 8'hd5);
      iop(cal_pkg::OP_IO_BIT_SET, 6'h0e, 3'h1, 8'hd7);
      iop(cal_pkg::OP_IO_BIT_CLEAR, 6'h0e, 3'h0, 8'hd6);
      iop(cal_pkg::OP_IO_BIT_SET, 6'h03, 3'h7, 8'h80);
      iop(cal_pkg::OP_IO_BIT_CLEAR, 6'h03, 3'h7, 8'h00);
      iop(cal_pkg::OP_IO_BIT_SET, 6'h1f, 3'h0, 8'h01);
      iop(cal_pkg::OP_IO_BIT_SET, 6'h20, 3'h0, 8'h00);
      check("io_writes", we_count, 8'h06);
      skp(cal_pkg::OP_SKIP_IF_IO_BIT_ONE, 6'h0e, 3'h7, 1'b1);
      skp(cal_pkg::OP_SKIP_IF_IO_BIT_ONE, 6'h0e, 3'h5, 1'b0);
      skp(cal_pkg::OP_SKIP_IF_IO_BIT_ZERO, 6'h0e, 3'h5, 1'b1);
      skp(cal_pkg::OP_SKIP_IF_IO_BIT_ONE, 6'h20, 3'h0, 1'b0);
      skp(cal_pkg::OP_SKIP_IF_IO_BIT_ZERO, 6'h0e, 3'h7, 1'b0);
      $display("io test done");
   endtask
   task automatic test_unmapped();
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped_read", er, 1'b1);
      apb(1'b1, 8'h1c, 32'hffff_ffff);
      check("unmapped_write", er, 1'b1);
      $display("unmapped test done");
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      test_reset();
      test_byte();
      test_word();
      test_io();
      test_unmapped();
      complete_run();
   end
endmodule
bind cal_core cal_core_chk cal_core_chk_i (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
   .IO_WMASK(IO_WMASK), .IO_WE(IO_WE), .IO_RDATA(IO_RDATA), .SKIP(SKIP));
`default_nettype wire
